// ==== tx_cfg_pkg.sv ====
// Shared constants and carriers for the transmitter configuration registers
package tx_cfg_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_GAUSS_STEP_CFG = 8'h04;
	localparam logic [7:0] ADDR_AMP_BOOST_CTRL = 8'h05;
	localparam logic [7:0] ADDR_AMP_POWER_CTRL = 8'h06;
	localparam logic [7:0] ADDR_AMP_TUNE_CAP   = 8'h07;
	localparam logic [7:0] ADDR_SYNTH_MODE_CFG = 8'h08;

	// ==========================================================
	// Field positions
	localparam int STEP_LSB      = 0;
	localparam int BOOST_BIT     = 0;
	localparam int BOOST_RSV_LSB = 1;
	localparam int DRV_LSB       = 0;
	localparam int PWR_RSV_LSB   = 5;
	localparam int CAP_LSB       = 0;
	localparam int SRC_BIT       = 0;
	localparam int DIV_LSB       = 1;
	localparam int SYN_RSV_LSB   = 3;
	localparam int FRAC_BIT      = 5;
	localparam int PUMP_LSB      = 6;

	// ==========================================================
	// Reset values
	localparam logic [5:0] RST_STEP      = 6'h00;
	localparam logic [0:0] RST_BOOST     = 1'h0;
	localparam logic [1:0] RST_BOOST_RSV = 2'h2;
	localparam logic [2:0] RST_DRV       = 3'h0;
	localparam logic [2:0] RST_PWR_RSV   = 3'h4;
	localparam logic [4:0] RST_CAP       = 5'h00;
	localparam logic [1:0] RST_PUMP      = 2'h1;
	localparam logic [0:0] RST_FRAC      = 1'h1;
	localparam logic [1:0] RST_SYN_RSV   = 2'h0;
	localparam logic [1:0] RST_DIV       = 2'h0;
	localparam logic [0:0] RST_SRC       = 1'h0;

	// ==========================================================
	// Decode figures
	localparam logic [3:0] PUMP_PCT_STEP = 4'h5;
	localparam logic [3:0] DIV_RATIO_STEP = 4'h4;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [3:0] pump_offset_pct;
		logic       fractional_loop_sel;
		logic [3:0] osc_div_ratio;
		logic       osc_source_sel;
	} synth_cfg_s;

endpackage

// ==== cfg_field.sv ====
// One writable configuration field with its own reset value
`timescale 1ns/1ps
module cfg_field
	import tx_cfg_pkg::*;
#(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Write side
	input  wire logic         we,
	input  wire logic [W-1:0] d,
	// Stored value
	output logic      [W-1:0] q
);

	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= RST;
		end else if (ce && we) begin
			q <= d;
		end
	end

endmodule

// ==== tx_pa_pll_config_regs.sv ====
// Shaping, amplifier and synthesizer configuration register slice
//
// Notes on behaviour
// [RULE1] Six-bit shaping step, read/write, resets zero
// [RULE2] Boost bit 0 selects boosted amplifier power
// [RULE3] Host writes fixed patterns into reserved bits
// [RULE4] Power code n enables n+1 drivers
// [RULE5] Pump offset code gives 0,5,10,15 percent
// [RULE6] Host zeroes pump offset in integer mode
// [RULE7] Bit 5 chooses fractional or integer loop
// [RULE8] Divider code gives off, 4, 8, 12
// [RULE9] Bit 0 chooses ring or LC oscillator
// [RULE10] Step applies only while shaping is enabled
// [RULE11] Reads return written fields, zero elsewhere
`timescale 1ns/1ps
module tx_pa_pll_config_regs
	import tx_cfg_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Register access from the serial port
	input  wire reg_req_s   req,
	output logic      [7:0] rdata_reg,
	output logic            rd_valid_reg,
	// Shaping enable from the first configuration register
	input  wire logic       gauss_shaping_en,
	// Shaping outputs
	output logic      [5:0] gauss_step_reg,
	output logic            shaping_active_reg,
	// Amplifier outputs
	output logic            amp_boost_en_reg,
	output logic      [7:0] amp_driver_en_reg,
	output logic      [4:0] amp_tune_capacitance_reg,
	// Synthesizer outputs
	output synth_cfg_s      synth_cfg_reg
);

	// ==========================================================
	// Address decode
	wire logic hit_step  = req.addr == ADDR_GAUSS_STEP_CFG;
	wire logic hit_boost = req.addr == ADDR_AMP_BOOST_CTRL;
	wire logic hit_pwr   = req.addr == ADDR_AMP_POWER_CTRL;
	wire logic hit_cap   = req.addr == ADDR_AMP_TUNE_CAP;
	wire logic hit_synth = req.addr == ADDR_SYNTH_MODE_CFG;
	wire logic we_step   = req.wr && hit_step;
	wire logic we_boost  = req.wr && hit_boost;
	wire logic we_pwr    = req.wr && hit_pwr;
	wire logic we_cap    = req.wr && hit_cap;
	wire logic we_synth  = req.wr && hit_synth;

	// ==========================================================
	// Stored fields
	logic [5:0] step_q;
	logic       boost_q;
	logic [1:0] boost_rsv_q;
	logic [2:0] drv_q;
	logic [2:0] pwr_rsv_q;
	logic [4:0] cap_q;
	logic [1:0] pump_q;
	logic       frac_q;
	logic [1:0] syn_rsv_q;
	logic [1:0] div_q;
	logic       src_q;

	cfg_field #(.W(6), .RST(RST_STEP)) u_step ( // RULE1
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_step),
		.d    (req.wdata[STEP_LSB +: 6]),
		.q    (step_q)
	);
	cfg_field #(.W(1), .RST(RST_BOOST)) u_boost ( // RULE2
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_boost),
		.d    (req.wdata[BOOST_BIT]),
		.q    (boost_q)
	);
	// Reserved bits are kept as written; the host owns their pattern
	cfg_field #(.W(2), .RST(RST_BOOST_RSV)) u_boost_rsv ( // RULE3
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_boost),
		.d    (req.wdata[BOOST_RSV_LSB +: 2]),
		.q    (boost_rsv_q)
	);
	cfg_field #(.W(3), .RST(RST_DRV)) u_drv ( // RULE4
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_pwr),
		.d    (req.wdata[DRV_LSB +: 3]),
		.q    (drv_q)
	);
	cfg_field #(.W(3), .RST(RST_PWR_RSV)) u_pwr_rsv ( // RULE3
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_pwr),
		.d    (req.wdata[PWR_RSV_LSB +: 3]),
		.q    (pwr_rsv_q)
	);
	cfg_field #(.W(5), .RST(RST_CAP)) u_cap (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_cap),
		.d    (req.wdata[CAP_LSB +: 5]),
		.q    (cap_q)
	);
	// Pump offset is not forced off in integer mode; host clears it
	cfg_field #(.W(2), .RST(RST_PUMP)) u_pump ( // RULE5 RULE6
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_synth),
		.d    (req.wdata[PUMP_LSB +: 2]),
		.q    (pump_q)
	);
	cfg_field #(.W(1), .RST(RST_FRAC)) u_frac ( // RULE7
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_synth),
		.d    (req.wdata[FRAC_BIT]),
		.q    (frac_q)
	);
	cfg_field #(.W(2), .RST(RST_SYN_RSV)) u_syn_rsv ( // RULE3
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_synth),
		.d    (req.wdata[SYN_RSV_LSB +: 2]),
		.q    (syn_rsv_q)
	);
	cfg_field #(.W(2), .RST(RST_DIV)) u_div ( // RULE8
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_synth),
		.d    (req.wdata[DIV_LSB +: 2]),
		.q    (div_q)
	);
	cfg_field #(.W(1), .RST(RST_SRC)) u_src ( // RULE9
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.we   (we_synth),
		.d    (req.wdata[SRC_BIT]),
		.q    (src_q)
	);

	// ==========================================================
	// Read images and read mux
	wire logic [7:0] img_step  = {2'h0, step_q};
	wire logic [7:0] img_boost = {5'h00, boost_rsv_q, boost_q};
	wire logic [7:0] img_pwr   = {pwr_rsv_q, 2'h0, drv_q};
	wire logic [7:0] img_cap   = {3'h0, cap_q};
	wire logic [7:0] img_synth = {pump_q, frac_q, syn_rsv_q, div_q, src_q};
	// Unmapped offsets read as zero
	wire logic [7:0] rd_mux    = hit_step  ? img_step  : // RULE11
	                             hit_boost ? img_boost :
	                             hit_pwr   ? img_pwr   :
	                             hit_cap   ? img_cap   :
	                             hit_synth ? img_synth : 8'h00;

	// ==========================================================
	// Decoders
	wire logic [8:0] drv_therm = (9'h002 << drv_q) - 9'h001; // RULE4
	wire logic [7:0] drv_next  = drv_therm[7:0];
	wire logic [5:0] step_next = gauss_shaping_en ? step_q : 6'h00; // RULE10
	wire logic [3:0] pump_next = PUMP_PCT_STEP * {2'h0, pump_q}; // RULE5
	wire logic [3:0] div_next  = DIV_RATIO_STEP * {2'h0, div_q}; // RULE8
	wire synth_cfg_s synth_next = '{
		pump_offset_pct:     pump_next,
		fractional_loop_sel: frac_q, // RULE7
		osc_div_ratio:       div_next,
		osc_source_sel:      src_q // RULE9
	};

	// ==========================================================
	// Output registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg    <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else if (ce) begin
			rdata_reg    <= req.rd ? rd_mux : rdata_reg; // RULE11
			rd_valid_reg <= req.rd;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			gauss_step_reg           <= 6'h00;
			shaping_active_reg       <= 1'b0;
			amp_boost_en_reg         <= 1'b0;
			amp_driver_en_reg        <= 8'h01;
			amp_tune_capacitance_reg <= 5'h00;
			synth_cfg_reg            <= '{4'h5, 1'b1, 4'h0, 1'b0};
		end else if (ce) begin
			gauss_step_reg           <= step_next; // RULE10
			shaping_active_reg       <= gauss_shaping_en;
			amp_boost_en_reg         <= boost_q; // RULE2
			amp_driver_en_reg        <= drv_next; // RULE4
			amp_tune_capacitance_reg <= cap_q;
			synth_cfg_reg            <= synth_next;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_read_req;
		ce && req.rd;
	endsequence
	sequence s_read_ans;
		rd_valid_reg && rdata_reg == $past(rd_mux);
	endsequence

	a_step_store: assert property ( // RULE1
		ce && we_step |=> step_q == $past(req.wdata[5:0])
	) else $error("shaping step not stored");
	a_step_gate: assert property ( // RULE10
		ce |=> gauss_step_reg ==
			($past(gauss_shaping_en) ? $past(step_q) : 6'h00)
	) else $error("shaping step not gated by enable");
	a_boost_follow: assert property ( // RULE2
		ce && we_boost ##1 ce |=> amp_boost_en_reg == $past(req.wdata[0], 2)
	) else $error("boost output wrong");
	a_driver_count: assert property ( // RULE4
		ce |=> $countones(amp_driver_en_reg) == {1'b0, $past(drv_q)} + 4'h1
			&& amp_driver_en_reg[0]
			&& amp_driver_en_reg == 8'hFF >> (3'h7 - $past(drv_q))
	) else $error("driver count wrong");
	a_pump_pct: assert property ( // RULE5
		ce |=> synth_cfg_reg.pump_offset_pct ==
			($past(pump_q) == 2'h0 ? 4'h0 : $past(pump_q) == 2'h1 ? 4'h5 :
			 $past(pump_q) == 2'h2 ? 4'hA : 4'hF)
	) else $error("pump offset decode wrong");
	a_loop_mode: assert property ( // RULE7
		ce && we_synth ##1 ce |=>
			synth_cfg_reg.fractional_loop_sel == $past(req.wdata[5], 2)
	) else $error("loop mode wrong");
	a_div_ratio: assert property ( // RULE8
		ce |=> synth_cfg_reg.osc_div_ratio ==
			($past(div_q) == 2'h0 ? 4'h0 : $past(div_q) == 2'h1 ? 4'h4 :
			 $past(div_q) == 2'h2 ? 4'h8 : 4'hC)
	) else $error("divider decode wrong");
	a_osc_source: assert property ( // RULE9
		ce |=> synth_cfg_reg.osc_source_sel == $past(src_q)
	) else $error("oscillator source wrong");
	a_read_back: assert property ( // RULE11
		s_read_req |=> s_read_ans
	) else $error("read data wrong");
	a_read_unmapped: assert property ( // RULE11
		ce && req.rd && !(hit_step || hit_boost || hit_pwr || hit_cap ||
		hit_synth) |=> rdata_reg == 8'h00
	) else $error("unmapped read not zero");

endmodule

// ==== cfg_host.sv ====
// Host model issuing byte reads and writes on the configuration port
`timescale 1ns/1ps
module cfg_host
	import tx_cfg_pkg::*;
(
	// Clock
	input  wire logic       mclk,
	// Requests and answers
	output reg_req_s        req,
	input  wire logic [7:0] rdata_reg,
	input  wire logic       rd_valid_reg
);
	initial req = '0;

	// ==========================================================
	// Write one byte, keeping the reserved patterns
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == ADDR_AMP_BOOST_CTRL)
			v[2:1] = 2'b10;
		if (a == ADDR_AMP_POWER_CTRL)
			v[7:5] = 3'b100;
		if (a == ADDR_SYNTH_MODE_CFG)
			v[4:3] = 2'b00;
		if (a == ADDR_SYNTH_MODE_CFG && !v[5])
			v[7:6] = 2'b00;
		@(posedge mclk);
		#1;
		req = '{1'b1, 1'b0, a, v};
		@(posedge mclk);
		#1;
		req = '{1'b0, 1'b0, ~a, ~v};
	endtask

	// ==========================================================
	// Read one byte just after the edge that takes the request
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge mclk);
		#1;
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk);
		#1;
		d = rdata_reg;
		v = rd_valid_reg;
		req = '{1'b0, 1'b0, ~a, 8'hFF};
	endtask
endmodule

// ==== test_tx_pa_pll_config_regs.sv ====
// Self-checking bench for the configuration register slice
`timescale 1ns/1ps
module test_tx_pa_pll_config_regs
	import tx_cfg_pkg::*;
;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic       gauss_shaping_en = 1'b0;
	reg_req_s   req;
	logic [7:0] rdata_reg;
	logic       rd_valid_reg;
	logic [5:0] gauss_step_reg;
	logic       shaping_active_reg;
	logic       amp_boost_en_reg;
	logic [7:0] amp_driver_en_reg;
	logic [4:0] amp_tune_capacitance_reg;
	synth_cfg_s synth_cfg_reg;
	int         errors = 0;
	int         n_tests = 0;

	always #2 mclk = ~mclk;

	tx_pa_pll_config_regs tx_pa_pll_config_regs_inst (.mclk, .rst, .ce,
		.req, .rdata_reg, .rd_valid_reg, .gauss_shaping_en,
		.gauss_step_reg, .shaping_active_reg, .amp_boost_en_reg,
		.amp_driver_en_reg, .amp_tune_capacitance_reg, .synth_cfg_reg);
	cfg_host cfg_host_inst (.mclk, .req, .rdata_reg, .rd_valid_reg);

	// ==========================================================
	// Access and compare tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_host_inst.wr(a, d);
		@(posedge mclk);
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		cfg_host_inst.rd(a, d, v);
		chk({v, d}, {1'b1, exp});
	endtask

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (16) @(posedge mclk);
		#1;
		rst = 1'b0;
		rchk(ADDR_GAUSS_STEP_CFG, 8'h00);
		rchk(ADDR_AMP_BOOST_CTRL, 8'h04);
		rchk(ADDR_AMP_POWER_CTRL, 8'h80);
		rchk(ADDR_AMP_TUNE_CAP, 8'h00);
		rchk(ADDR_SYNTH_MODE_CFG, 8'h60);
		rchk(8'h09, 8'h00);
		step();
		chk(rd_valid_reg, 1'b0);
		chk(amp_driver_en_reg, 8'h01);
		chk(synth_cfg_reg, {4'h5, 1'b1, 4'h0, 1'b0});
		chk({amp_boost_en_reg, gauss_step_reg}, 7'h00);
		// Step is held at zero until shaping is enabled
		wr(ADDR_GAUSS_STEP_CFG, 8'hFF);
		rchk(ADDR_GAUSS_STEP_CFG, 8'h3F);
		chk(gauss_step_reg, 6'h00);
		gauss_shaping_en = 1'b1;
		step();
		chk({shaping_active_reg, gauss_step_reg}, 7'h7F);
		gauss_shaping_en = 1'b0;
		step();
		chk(gauss_step_reg, 6'h00);
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_AMP_POWER_CTRL, 8'h80 | 8'(n));
			chk(amp_driver_en_reg, 16'((1 << (n + 1)) - 1));
		end
		rchk(ADDR_AMP_POWER_CTRL, 8'h87);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_SYNTH_MODE_CFG, 8'(c * 64 + 32 + c * 2 + c % 2));
			chk(synth_cfg_reg, {4'(c * 5), 1'b1, 4'(c * 4), 1'(c % 2)});
		end
		// Integer mode with the pump offset cleared by the host
		wr(ADDR_SYNTH_MODE_CFG, 8'hC3);
		chk(synth_cfg_reg, {4'h0, 1'b0, 4'h4, 1'b1});
		rchk(ADDR_SYNTH_MODE_CFG, 8'h03);
		wr(ADDR_AMP_BOOST_CTRL, 8'h01);
		chk(amp_boost_en_reg, 1'b1);
		rchk(ADDR_AMP_BOOST_CTRL, 8'h05);
		wr(ADDR_AMP_BOOST_CTRL, 8'h00);
		chk(amp_boost_en_reg, 1'b0);
		wr(ADDR_AMP_TUNE_CAP, 8'hFF);
		chk(amp_tune_capacitance_reg, 5'h1F);
		rchk(ADDR_AMP_TUNE_CAP, 8'h1F);
		// A write while the clock enable is low leaves the field alone
		ce = 1'b0;
		cfg_host_inst.wr(ADDR_AMP_TUNE_CAP, 8'h00);
		ce = 1'b1;
		rchk(ADDR_AMP_TUNE_CAP, 8'h1F);
		// Reset restores fields and outputs even with the enable low
		ce = 1'b0;
		rst = 1'b1;
		repeat (2) step();
		rst = 1'b0;
		ce = 1'b1;
		chk(amp_tune_capacitance_reg, 5'h00);
		chk(synth_cfg_reg, {4'h5, 1'b1, 4'h0, 1'b0});
		rchk(ADDR_AMP_TUNE_CAP, 8'h00);
		rchk(ADDR_SYNTH_MODE_CFG, 8'h60);
		conclude();
	end

	initial begin
		#20000;
		errors++;
		conclude();
	end
endmodule
